// File: core/sdram_sched_pkg.sv
/*
 Shared constants, encodings and command decode for the precharge and
 write scheduling pair. Assumes a single 20 MHz command clock on both ends.
*/
package sdram_sched_pkg;
	localparam int TCK_PS       = 50000;
	localparam int BURST_LENGTH = 8;
	localparam int HALF_BURST   = BURST_LENGTH / 2;
	localparam int BANKS        = 8;
	localparam int WRITE_LATENCY = 6;
	localparam int COLUMN_TO_COLUMN_GAP = 4;
	localparam int PREFETCH_BEATS = 8;
	localparam int CA_WIDTH     = 10;
	localparam int BANK_W       = 3;
	localparam int COL_W        = 11;
	localparam int CNT_W        = 6;

	// Analog times in picoseconds
	localparam int WRITE_TO_READ_DELAY_PS    = 7500;
	localparam int WRITE_RECOVERY_PS         = 15000;
	localparam int READ_TO_PRECHARGE_PS      = 7500;
	localparam int ALL_BANK_CLOSE_TIME_PS    = 21000;
	localparam int SINGLE_BANK_CLOSE_TIME_PS = 18000;
	localparam int ROW_ACTIVE_MIN_PS         = 42000;
	localparam int ROW_CYCLE_TIME_PS         = 63000;

	// Field positions on the command/address bus
	localparam int CA_ALL_BANK    = 4;
	localparam int CA_BANK_LO     = 7;
	localparam int CA_COL_RISE_LO = 5;
	localparam int CA_COL_FALL_LO = 1;
	localparam int CA_AUTO_CLOSE  = 0;

	// Least times round up, never below one cycle
	function automatic int cycles_up(input int ps);
		int c;
		c = (ps + TCK_PS - 1) / TCK_PS;
		return (c < 1) ? 1 : c;
	endfunction

	localparam int WTR_CYC  = cycles_up(WRITE_TO_READ_DELAY_PS);
	localparam int WR_CYC   = cycles_up(WRITE_RECOVERY_PS);
	localparam int RTP_CYC  = cycles_up(READ_TO_PRECHARGE_PS);
	localparam int RPAB_CYC = cycles_up(ALL_BANK_CLOSE_TIME_PS);
	localparam int RPPB_CYC = cycles_up(SINGLE_BANK_CLOSE_TIME_PS);
	localparam int RAS_CYC  = cycles_up(ROW_ACTIVE_MIN_PS);
	localparam int RC_CYC   = cycles_up(ROW_CYCLE_TIME_PS);
	localparam int RD_AP_CYC = (HALF_BURST > HALF_BURST - 2 + RTP_CYC) ?
		HALF_BURST : HALF_BURST - 2 + RTP_CYC;
	localparam int RD_PRE_CYC = HALF_BURST + ((RTP_CYC > 4) ? RTP_CYC : 4) - 4;

	typedef enum logic [1:0] {
		OP_ACTIVATE = 2'h0,
		OP_READ     = 2'h1,
		OP_WRITE    = 2'h2,
		OP_CLOSE    = 2'h3
	} user_op_t;

	typedef enum logic [2:0] {
		LC_NONE  = 3'h0,
		LC_ACT   = 3'h1,
		LC_WRITE = 3'h2,
		LC_READ  = 3'h3,
		LC_PRE   = 3'h4,
		LC_OTHER = 3'h5
	} link_cmd_t;

	function automatic link_cmd_t decode_cmd(input logic csN,
		input logic [CA_WIDTH-1:0] ca);
		link_cmd_t c;
		c = LC_OTHER;
		if (csN)
			c = LC_NONE;
		else if (!ca[0] && ca[1])
			c = LC_ACT;
		else if (ca[0] && !ca[1] && !ca[2])
			c = LC_WRITE;
		else if (ca[0] && !ca[1] && ca[2])
			c = LC_READ;
		else if (ca[0] && ca[1] && !ca[2] && ca[3])
			c = LC_PRE;
		return c;
	endfunction
endpackage

// File: core/link_if.sv
/*
 Command, address and write data link between controller and device.
 Assumes both ends share core_clk; every signal is driven by the controller.
*/
`timescale 1ns/1ns
`default_nettype none
interface link_if #(
	parameter int DATA_W = 32,
	parameter int MASK_W = 4
) (
	input wire logic core_clk
);
	logic                                   csN;
	logic [sdram_sched_pkg::CA_WIDTH-1:0]   caRise;
	logic [sdram_sched_pkg::CA_WIDTH-1:0]   caFall;
	logic [DATA_W-1:0]                      dqRise;
	logic [DATA_W-1:0]                      dqFall;
	logic [MASK_W-1:0]                      maskRise;
	logic [MASK_W-1:0]                      maskFall;
	logic                                   dataValid;

	modport controller (
		output csN,
		output caRise,
		output caFall,
		output dqRise,
		output dqFall,
		output maskRise,
		output maskFall,
		output dataValid
	);

	// Masks are inputs only at the device
	modport device (
		input csN,
		input caRise,
		input caFall,
		input dqRise,
		input dqFall,
		input maskRise,
		input maskFall,
		input dataValid
	);
endinterface
`default_nettype wire

// File: core/count_timer.sv
/*
 Down counter that tells when a least spacing has run out.
 Assumes load is a one-cycle pulse; a load of n makes expired rise n cycles
 later, or n-1 if the count already holds n-1; a shorter load never shortens a running wait.
*/
`timescale 1ns/1ns
`default_nettype none
module count_timer #(
	parameter int W = 6
) (
	input  wire logic         core_clk,
	input  wire logic         rstn,
	input  wire logic         load,
	input  wire logic [W-1:0] value,
	output logic              expired
);
	typedef struct packed {
		logic [W-1:0] count;
	} state_t;

	state_t stateReg;
	state_t stateNext;

	always_comb begin
		stateNext = stateReg;
		if (load && value != '0 && (value - 1'b1) > stateReg.count)
			stateNext.count = value - 1'b1;
		else if (stateReg.count != '0)
			stateNext.count = stateReg.count - 1'b1;
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn)
			stateReg <= '0;
		else
			stateReg <= stateNext;
	end

	assign expired = (stateReg.count == '0);
endmodule
`default_nettype wire

// File: core/sdram_device_end.sv
/*
 Device end: decodes link commands, keeps per-bank open state, gathers
 write bursts into eight-beat groups and closes banks on precharge or
 automatic close. Assumes the controller keeps every spacing it owns.
*/
`timescale 1ns/1ns
`default_nettype none
module sdram_device_end #(
	parameter int WL     = sdram_sched_pkg::WRITE_LATENCY,
	parameter int DATA_W = 32,
	parameter int MASK_W = 4
) (
	input  wire logic                     core_clk,
	input  wire logic                     rstn,
	link_if.device                        link,
	output logic [7:0]                    bankOpen,
	output logic [7:0]                    bankReady,
	output logic                          arrayWrite,
	output logic [2:0]                    arrayBank,
	output logic [10:0]                   arrayColumn,
	output logic [8*DATA_W-1:0]           arrayData,
	output logic [8*MASK_W-1:0]           arrayMask
);
	localparam int NB = sdram_sched_pkg::BANKS;
	localparam int CW = sdram_sched_pkg::CNT_W;
	localparam logic [CW-1:0] RD_AP_CNT = CW'(sdram_sched_pkg::RD_AP_CYC);
	localparam logic [CW-1:0] WR_AP_CNT = CW'(sdram_sched_pkg::WR_CYC);
	localparam logic [CW-1:0] RPAB_CNT  = CW'(sdram_sched_pkg::RPAB_CYC);
	localparam logic [CW-1:0] RPPB_CNT  = CW'(sdram_sched_pkg::RPPB_CYC);
	localparam logic [1:0]    LAST_BEAT = 2'h3;

	typedef struct packed {
		logic        valid;
		logic [2:0]  bank;
		logic [10:0] col;
		logic        autoClose;
	} slot_t;

	typedef enum logic {
		GATHER_IDLE = 1'b0,
		GATHER_BUSY = 1'b1
	} gather_t;

	typedef struct packed {
		logic [NB-1:0]        open;
		logic [NB-1:0]        closePend;
		slot_t [WL-1:0]       pipe;
		gather_t              gather;
		logic [1:0]           beat;
		slot_t                cur;
		logic [8*DATA_W-1:0]  data;
		logic [8*MASK_W-1:0]  mask;
		logic                 done;
	} state_t;

	state_t                 stateReg;
	state_t                 stateNext;
	sdram_sched_pkg::link_cmd_t cmd;
	logic [2:0]             cmdBank;
	logic [NB-1:0]          apLoad;
	logic [CW-1:0]          apVal [NB];
	logic [NB-1:0]          apZero;
	logic [NB-1:0]          rdyLoad;
	logic [CW-1:0]          rdyVal [NB];
	logic [NB-1:0]          rdyZero;

	always_comb begin
		int idx;
		idx = 0;
		stateNext = stateReg;
		stateNext.done = 1'b0;
		apLoad = '0;
		rdyLoad = '0;
		for (int b = 0; b < NB; b++) begin
			apVal[b] = '0;
			rdyVal[b] = '0;
		end
		cmd = sdram_sched_pkg::decode_cmd(link.csN, link.caRise);
		cmdBank = link.caRise[sdram_sched_pkg::CA_BANK_LO +: 3];

		// Write slots ride a WL-deep line so data is expected on time
		for (int i = 0; i < WL - 1; i++)
			stateNext.pipe[i] = stateReg.pipe[i + 1];
		stateNext.pipe[WL-1] = '0;

		// Automatic close once its wait has run out
		for (int b = 0; b < NB; b++) begin
			if (stateReg.closePend[b] && apZero[b]) begin
				stateNext.open[b] = 1'b0;
				stateNext.closePend[b] = 1'b0;
				rdyLoad[b] = 1'b1;
				rdyVal[b] = RPPB_CNT;
			end
		end

		case (cmd)
			sdram_sched_pkg::LC_ACT: begin
				stateNext.open[cmdBank] = 1'b1;
			end
			sdram_sched_pkg::LC_WRITE: begin
				stateNext.pipe[WL-1].valid = 1'b1;
				stateNext.pipe[WL-1].bank = cmdBank;
				stateNext.pipe[WL-1].col = {link.caFall[9:1],
					link.caRise[6:5]};
				stateNext.pipe[WL-1].autoClose =
					link.caFall[sdram_sched_pkg::CA_AUTO_CLOSE];
			end
			sdram_sched_pkg::LC_READ: begin
				// Flag low: nothing scheduled, bank stays open
				if (link.caFall[sdram_sched_pkg::CA_AUTO_CLOSE]) begin
					stateNext.closePend[cmdBank] = 1'b1;
					apLoad[cmdBank] = 1'b1;
					apVal[cmdBank] = RD_AP_CNT;
				end
			end
			sdram_sched_pkg::LC_PRE: begin
				if (link.caRise[sdram_sched_pkg::CA_ALL_BANK]) begin
					stateNext.open = '0;
					stateNext.closePend = '0;
					for (int b = 0; b < NB; b++) begin
						rdyLoad[b] = 1'b1;
						rdyVal[b] = RPAB_CNT;
					end
				end else if (stateReg.open[cmdBank]) begin
					stateNext.open[cmdBank] = 1'b0;
					stateNext.closePend[cmdBank] = 1'b0;
					rdyLoad[cmdBank] = 1'b1;
					rdyVal[cmdBank] = RPPB_CNT;
				end
			end
			default: begin
			end
		endcase

		// Gather beats; a new slot at the head always starts beat 0
		if (stateReg.pipe[0].valid || stateReg.gather == GATHER_BUSY) begin
			if (stateReg.pipe[0].valid) begin
				idx = 0;
				stateNext.cur = stateReg.pipe[0];
				stateNext.beat = 2'h1;
				stateNext.gather = GATHER_BUSY;
			end else begin
				idx = int'(stateReg.beat);
				stateNext.beat = stateReg.beat + 2'h1;
				if (stateReg.beat == LAST_BEAT) begin
					stateNext.gather = GATHER_IDLE;
					stateNext.done = 1'b1;
					if (stateReg.cur.autoClose) begin
						stateNext.closePend[stateReg.cur.bank] = 1'b1;
						apLoad[stateReg.cur.bank] = 1'b1;
						apVal[stateReg.cur.bank] = WR_AP_CNT;
					end
				end
			end
			stateNext.data[2*idx*DATA_W +: DATA_W] = link.dqRise;
			stateNext.data[(2*idx+1)*DATA_W +: DATA_W] = link.dqFall;
			// Masks sampled on the same beats as data; no data means no write
			stateNext.mask[2*idx*MASK_W +: MASK_W] = link.dataValid ?
				link.maskRise : '1;
			stateNext.mask[(2*idx+1)*MASK_W +: MASK_W] = link.dataValid ?
				link.maskFall : '1;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn)
			stateReg <= '0;
		else
			stateReg <= stateNext;
	end

	for (genvar b = 0; b < NB; b++) begin : g_bank
		count_timer #(
			.W(CW)
		) u_close_wait (
			.core_clk(core_clk),
			.rstn    (rstn),
			.load    (apLoad[b]),
			.value   (apVal[b]),
			.expired (apZero[b])
		);
		count_timer #(
			.W(CW)
		) u_ready_wait (
			.core_clk(core_clk),
			.rstn    (rstn),
			.load    (rdyLoad[b]),
			.value   (rdyVal[b]),
			.expired (rdyZero[b])
		);
	end

	// Group outputs stay valid in the done cycle; the next group
	// overwrites them only at the following edge
	assign bankOpen = stateReg.open;
	assign bankReady = ~stateReg.open & rdyZero;
	assign arrayWrite = stateReg.done;
	assign arrayBank = stateReg.cur.bank;
	assign arrayColumn = stateReg.cur.col;
	assign arrayData = stateReg.data;
	assign arrayMask = stateReg.mask;
endmodule
`default_nettype wire

// File: core/sdram_controller_end.sv
/*
 Controller end: takes user commands, holds each one off until its
 per-bank (activate, close) or global (read, write) spacing timers allow it, drives the command bus and
 plays write data out WL cycles after the write. Assumes the device end
 on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
module sdram_controller_end #(
	parameter int WL     = sdram_sched_pkg::WRITE_LATENCY,
	parameter int DATA_W = 32,
	parameter int MASK_W = 4
) (
	input  wire logic                        core_clk,
	input  wire logic                        rstn,
	link_if.controller                       link,
	input  wire logic                        cmdValid,
	output logic                             cmdReady,
	input  wire sdram_sched_pkg::user_op_t   cmdOp,
	input  wire logic [2:0]                  cmdBank,
	input  wire logic                        cmdAll,
	input  wire logic                        cmdAutoClose,
	input  wire logic [10:0]                 cmdColumn,
	input  wire logic [8*DATA_W-1:0]         wrData,
	input  wire logic [8*MASK_W-1:0]         wrMask
);
	localparam int NB = sdram_sched_pkg::BANKS;
	localparam int CW = sdram_sched_pkg::CNT_W;
	localparam int HB = sdram_sched_pkg::HALF_BURST;
	localparam int WRP = WL + HB + 1 + sdram_sched_pkg::WR_CYC;
	localparam logic [CW-1:0] RAS_CNT  = CW'(sdram_sched_pkg::RAS_CYC);
	localparam logic [CW-1:0] RC_CNT   = CW'(sdram_sched_pkg::RC_CYC);
	localparam logic [CW-1:0] RPAB_CNT = CW'(sdram_sched_pkg::RPAB_CYC);
	localparam logic [CW-1:0] RPPB_CNT = CW'(sdram_sched_pkg::RPPB_CYC);
	localparam logic [CW-1:0] COL_CNT  =
		CW'(sdram_sched_pkg::COLUMN_TO_COLUMN_GAP);
	localparam logic [CW-1:0] RD_PRE_CNT = CW'(sdram_sched_pkg::RD_PRE_CYC);
	localparam logic [CW-1:0] RD_ACT_CNT =
		CW'(sdram_sched_pkg::RD_PRE_CYC + sdram_sched_pkg::RPPB_CYC);
	localparam logic [CW-1:0] WR_RD_CNT  =
		CW'(WL + 1 + HB + sdram_sched_pkg::WTR_CYC);
	localparam logic [CW-1:0] WR_PRE_CNT = CW'(WRP);
	localparam logic [CW-1:0] WR_ACT_CNT =
		CW'(WRP + sdram_sched_pkg::RPPB_CYC);

	typedef struct packed {
		logic              valid;
		logic [DATA_W-1:0] dR;
		logic [DATA_W-1:0] dF;
		logic [MASK_W-1:0] mR;
		logic [MASK_W-1:0] mF;
	} beat_t;

	typedef struct packed {
		beat_t [WL+3:0] pipe;
		logic           csN;
		logic [9:0]     caR;
		logic [9:0]     caF;
	} state_t;

	state_t        stateReg;
	state_t        stateNext;
	logic [NB-1:0] actLoad;
	logic [CW-1:0] actVal [NB];
	logic [NB-1:0] actZero;
	logic [NB-1:0] preLoad;
	logic [CW-1:0] preVal [NB];
	logic [NB-1:0] preZero;
	logic          colLoad;
	logic          colZero;
	logic          rdLoad;
	logic          rdZero;

	always_comb begin
		case (cmdOp)
			sdram_sched_pkg::OP_ACTIVATE: cmdReady = actZero[cmdBank];
			sdram_sched_pkg::OP_READ:     cmdReady = colZero && rdZero;
			sdram_sched_pkg::OP_WRITE:    cmdReady = colZero;
			sdram_sched_pkg::OP_CLOSE:    cmdReady = cmdAll ? &preZero :
				preZero[cmdBank];
			default:                      cmdReady = 1'b0;
		endcase
	end

	always_comb begin
		stateNext = stateReg;
		for (int i = 0; i < WL + 3; i++)
			stateNext.pipe[i] = stateReg.pipe[i + 1];
		stateNext.pipe[WL+3] = '0;
		stateNext.csN = 1'b1;
		stateNext.caR = '0;
		stateNext.caF = '0;
		actLoad = '0;
		preLoad = '0;
		colLoad = 1'b0;
		rdLoad = 1'b0;
		for (int b = 0; b < NB; b++) begin
			actVal[b] = '0;
			preVal[b] = '0;
		end
		if (cmdValid && cmdReady) begin
			stateNext.csN = 1'b0;
			stateNext.caR[9:7] = cmdBank;
			case (cmdOp)
				sdram_sched_pkg::OP_ACTIVATE: begin
					stateNext.caR[1] = 1'b1;
					actLoad[cmdBank] = 1'b1;
					actVal[cmdBank] = RC_CNT;
					preLoad[cmdBank] = 1'b1;
					preVal[cmdBank] = RAS_CNT;
				end
				sdram_sched_pkg::OP_READ, sdram_sched_pkg::OP_WRITE: begin
					stateNext.caR[0] = 1'b1;
					stateNext.caR[2] = (cmdOp == sdram_sched_pkg::OP_READ);
					stateNext.caR[6:5] = cmdColumn[1:0];
					stateNext.caF[9:1] = cmdColumn[10:2];
					stateNext.caF[0] = cmdAutoClose;
					colLoad = 1'b1;
					preLoad[cmdBank] = 1'b1;
					actLoad[cmdBank] = cmdAutoClose;
					if (cmdOp == sdram_sched_pkg::OP_READ) begin
						preVal[cmdBank] = RD_PRE_CNT;
						actVal[cmdBank] = RD_ACT_CNT;
					end else begin
						rdLoad = 1'b1;
						preVal[cmdBank] = WR_PRE_CNT;
						actVal[cmdBank] = WR_ACT_CNT;
						for (int k = 0; k < 4; k++) begin
							stateNext.pipe[WL+k].valid = 1'b1;
							stateNext.pipe[WL+k].dR = wrData[2*k*DATA_W +: DATA_W];
							stateNext.pipe[WL+k].dF =
								wrData[(2*k+1)*DATA_W +: DATA_W];
							stateNext.pipe[WL+k].mR = wrMask[2*k*MASK_W +: MASK_W];
							stateNext.pipe[WL+k].mF =
								wrMask[(2*k+1)*MASK_W +: MASK_W];
						end
					end
				end
				default: begin
					stateNext.caR[3:0] = 4'hB;
					stateNext.caR[4] = cmdAll;
					for (int b = 0; b < NB; b++) begin
						if (cmdAll || cmdBank == 3'(b)) begin
							actLoad[b] = 1'b1;
							actVal[b] = cmdAll ? RPAB_CNT : RPPB_CNT;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			stateReg <= '0;
			stateReg.csN <= 1'b1;
		end else begin
			stateReg <= stateNext;
		end
	end

	for (genvar b = 0; b < NB; b++) begin : g_bank
		count_timer #(
			.W(CW)
		) u_act_wait (
			.core_clk(core_clk),
			.rstn    (rstn),
			.load    (actLoad[b]),
			.value   (actVal[b]),
			.expired (actZero[b])
		);
		count_timer #(
			.W(CW)
		) u_pre_wait (
			.core_clk(core_clk),
			.rstn    (rstn),
			.load    (preLoad[b]),
			.value   (preVal[b]),
			.expired (preZero[b])
		);
	end

	count_timer #(
		.W(CW)
	) u_col_wait (
		.core_clk(core_clk),
		.rstn    (rstn),
		.load    (colLoad),
		.value   (COL_CNT),
		.expired (colZero)
	);

	count_timer #(
		.W(CW)
	) u_rd_wait (
		.core_clk(core_clk),
		.rstn    (rstn),
		.load    (rdLoad),
		.value   (WR_RD_CNT),
		.expired (rdZero)
	);

	assign link.csN = stateReg.csN;
	assign link.caRise = stateReg.caR;
	assign link.caFall = stateReg.caF;
	assign link.dqRise = stateReg.pipe[0].dR;
	assign link.dqFall = stateReg.pipe[0].dF;
	assign link.maskRise = stateReg.pipe[0].mR;
	assign link.maskFall = stateReg.pipe[0].mF;
	assign link.dataValid = stateReg.pipe[0].valid;
endmodule
`default_nettype wire

// File: tb/sdram_sched_sva.sv
/*
 Link-side assertions and covers for the controller and device pair.
 Assumes it watches the one link_if that joins the two design ends.
*/
`timescale 1ns/1ns
`default_nettype none
module sdram_sched_sva (
	input wire logic       core_clk,
	input wire logic       rstn,
	input wire logic       csN,
	input wire logic [9:0] caRise,
	input wire logic [9:0] caFall,
	input wire logic       dataValid
);
	logic       isWr;
	logic       isRd;
	logic       isPre;
	logic       isAct;
	logic [3:0] wrCnt_reg;
	logic [1:0] rdCnt_reg;
	logic [2:0] wrBank_reg;
	logic [2:0] rdBank_reg;

	assign isWr = !csN && caRise[2:0] == 3'h1;
	assign isRd = !csN && caRise[2:0] == 3'h5;
	assign isPre = !csN && caRise[3:0] == 4'hB;
	assign isAct = !csN && caRise[1:0] == 2'h2;

	// Only the latest write and read are tracked: an older one may be
	// missed, but nothing legal is ever flagged
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			wrCnt_reg <= 4'h0;
			rdCnt_reg <= 2'h0;
			wrBank_reg <= 3'h0;
			rdBank_reg <= 3'h0;
		end else begin
			wrCnt_reg <= isWr ? 4'hB : wrCnt_reg - 4'(wrCnt_reg != 4'h0);
			rdCnt_reg <= isRd ? 2'h3 : rdCnt_reg - 2'(rdCnt_reg != 2'h0);
			if (isWr)
				wrBank_reg <= caRise[9:7];
			if (isRd)
				rdBank_reg <= caRise[9:7];
		end
	end

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rstn);

	wr_rd_gap_a: assert property (isWr |=> (!isRd)[*8] ##1 (!isRd)[*3])
		else $error("read too soon after write");
	wr_pre_gap_a: assert property (isPre && wrCnt_reg != 4'h0 |->
		!caRise[4] && caRise[9:7] != wrBank_reg)
		else $error("precharge too soon after write");
	rd_pre_gap_a: assert property (isPre && rdCnt_reg != 2'h0 |->
		!caRise[4] && caRise[9:7] != rdBank_reg)
		else $error("precharge too soon after read");
	col_gap_a: assert property (isWr || isRd |=> (!(isWr || isRd))[*3])
		else $error("column commands closer than four");
	wr_data_a: assert property (isWr |-> ##6 dataValid[*4])
		else $error("write burst not four data cycles at latency");
	data_start_a: assert property ($rose(dataValid) |-> $past(isWr, 6))
		else $error("data started without a write");
	data_end_a: assert property ($fell(dataValid) |-> $past(isWr, 10))
		else $error("write burst ended at wrong cycle");
	act_gap_a: assert property (isAct |=>
		!(isAct && caRise[9:7] == $past(caRise[9:7])))
		else $error("activates to one bank too close");

	cover property (isWr ##4 isWr);
	cover property (isPre && caRise[4]);
	cover property (isRd && caFall[0]);
	cover property (isWr && caFall[0]);
endmodule
`default_nettype wire

// File: tb/sdram_precharge_write_sched_tb.sv
/*
 Self-checking bench: controller end drives device end over link_if.
 Assumes the hand-over timing: command on the link one cycle after it is
 taken, WL of 6, write group written ten cycles after the link command.
*/
`timescale 1ns/1ns
`default_nettype none
module sdram_precharge_write_sched_tb;
	logic                      core_clk;
	logic                      rstn;
	logic                      cmdValid;
	logic                      cmdReady;
	sdram_sched_pkg::user_op_t cmdOp;
	logic [2:0]                cmdBank;
	logic                      cmdAll;
	logic                      cmdAutoClose;
	logic [10:0]               cmdColumn;
	logic [255:0]              wrData;
	logic [31:0]               wrMask;
	logic [7:0]                bankOpen;
	logic [7:0]                bankReady;
	logic                      arrayWrite;
	logic [2:0]                arrayBank;
	logic [10:0]               arrayColumn;
	logic [255:0]              arrayData;
	logic [31:0]               arrayMask;
	logic [301:0]              expQ[$];
	int                        errors;
	int                        n_compared;
	time                       tk;

	link_if link_if_i (.core_clk(core_clk));
	sdram_controller_end sdram_controller_end_i (
		.core_clk(core_clk),
		.rstn(rstn),
		.link(link_if_i.controller),
		.cmdValid(cmdValid),
		.cmdReady(cmdReady),
		.cmdOp(cmdOp),
		.cmdBank(cmdBank),
		.cmdAll(cmdAll),
		.cmdAutoClose(cmdAutoClose),
		.cmdColumn(cmdColumn),
		.wrData(wrData),
		.wrMask(wrMask)
	);
	sdram_device_end sdram_device_end_i (
		.core_clk(core_clk),
		.rstn(rstn),
		.link(link_if_i.device),
		.bankOpen(bankOpen),
		.bankReady(bankReady),
		.arrayWrite(arrayWrite),
		.arrayBank(arrayBank),
		.arrayColumn(arrayColumn),
		.arrayData(arrayData),
		.arrayMask(arrayMask)
	);
	sdram_sched_sva sdram_sched_sva_i (
		.core_clk(core_clk),
		.rstn(rstn),
		.csN(link_if_i.csN),
		.caRise(link_if_i.caRise),
		.caFall(link_if_i.caFall),
		.dataValid(link_if_i.dataValid)
	);

	function automatic int ru(input int ps);
		return (ps + 49999) / 50000;
	endfunction

	task automatic check(input logic [301:0] seen, input logic [301:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("Error at %0t: saw %0h expected %0h", $time, seen, exp);
		end
	endtask

	task automatic close_out();
		$display("Compared %0d, mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Op codes: 0 activate, 1 read, 2 write, 3 close
	task automatic issue(input logic [1:0] op, input logic [2:0] bank,
		input logic all, input logic ap, input logic [31:0] m);
		logic [255:0] d;
		logic [10:0]  c;
		int           n;
		for (int i = 0; i < 8; i++)
			d[32*i +: 32] = $urandom;
		c = 11'($urandom);
		n = 0;
		@(posedge core_clk);
		cmdValid <= 1'b1;
		cmdOp <= sdram_sched_pkg::user_op_t'(op);
		cmdBank <= bank;
		cmdAll <= all;
		cmdAutoClose <= ap;
		cmdColumn <= c;
		wrData <= d;
		wrMask <= m;
		@(negedge core_clk);
		while (cmdReady !== 1'b1 && n < 100) begin
			n++;
			@(negedge core_clk);
		end
		check(1'(n < 100), 1'b1);
		@(posedge core_clk);
		tk = $time;
		cmdValid <= 1'b0;
		if (op == 2'h2)
			expQ.push_back({bank, c, d, m});
	endtask

	// Lands mid-cycle k cycles after the link command cycle
	task automatic at(input int k);
		repeat (k) @(posedge core_clk);
		@(negedge core_clk);
	endtask

	always @(negedge core_clk) begin
		if (rstn === 1'b1 && arrayWrite === 1'b1) begin
			if (expQ.size() == 0)
				check(1'b1, 1'b0);
			else
				check({arrayBank, arrayColumn, arrayData, arrayMask}, expQ.pop_front());
		end
	end

	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end

	// The sequence needs a few hundred cycles; 20000 leaves wide margin
	initial begin
		#1000000;
		errors++;
		$display("Error at %0t: watchdog expired", $time);
		close_out();
	end

	initial begin
		time t0;
		int  e;
		rstn = 1'b0;
		cmdValid = 1'b0;
		cmdOp = sdram_sched_pkg::OP_ACTIVATE;
		cmdBank = 3'h0;
		cmdAll = 1'b0;
		cmdAutoClose = 1'b0;
		cmdColumn = 11'h000;
		wrData = '0;
		wrMask = 32'h0;
		errors = 0;
		n_compared = 0;
		tk = 0;
		void'($urandom(32'h97DBCF22));
		repeat (7) @(posedge core_clk);
		@(negedge core_clk);
		check({bankOpen, bankReady, arrayWrite}, 17'h001FE);
		@(posedge core_clk);
		rstn <= 1'b1;
		for (int b = 0; b < 8; b++)
			issue(2'h0, 3'(b), 1'b0, 1'b0, 32'h0);
		at(1);
		check(bankOpen, 8'hFF);
		// Full mask, second beat masked, then random masks
		for (int i = 0; i < 6; i++) begin
			t0 = tk;
			issue(2'h2, 3'($urandom), 1'b0, 1'b0,
				(i == 0) ? 32'hFFFFFFFF : (i == 1) ? 32'h000000F0 : $urandom);
			if (i > 0)
				check((tk - t0) / 50, 4);
		end
		issue(2'h2, 3'h2, 1'b0, 1'b0, $urandom);
		t0 = tk;
		issue(2'h1, 3'h2, 1'b0, 1'b0, 32'h0);
		e = sdram_sched_pkg::WRITE_LATENCY + 5;
		e = e + ru(sdram_sched_pkg::WRITE_TO_READ_DELAY_PS);
		check((tk - t0) / 50, e);
		t0 = tk;
		issue(2'h3, 3'h2, 1'b0, 1'b0, 32'h0);
		e = ru(sdram_sched_pkg::READ_TO_PRECHARGE_PS);
		e = 4 + ((e > 4) ? e : 4) - 4;
		check((tk - t0) / 50, e);
		at(1);
		check({bankOpen, bankReady}, 16'hFB04);
		issue(2'h3, 3'h2, 1'b0, 1'b0, 32'h0);
		at(1);
		check({bankOpen, bankReady}, 16'hFB04);
		issue(2'h2, 3'h4, 1'b0, 1'b0, $urandom);
		t0 = tk;
		issue(2'h3, 3'h4, 1'b0, 1'b0, 32'h0);
		e = sdram_sched_pkg::WRITE_LATENCY + 5;
		e = e + ru(sdram_sched_pkg::WRITE_RECOVERY_PS);
		check((tk - t0) / 50, e);
		issue(2'h3, 3'h0, 1'b1, 1'b0, 32'h0);
		at(1);
		check({bankOpen, bankReady}, 16'h00FF);
		issue(2'h0, 3'h3, 1'b0, 1'b0, 32'h0);
		issue(2'h0, 3'h5, 1'b0, 1'b0, 32'h0);
		issue(2'h1, 3'h3, 1'b0, 1'b1, 32'h0);
		at(4);
		check(bankOpen, 8'h28);
		at(1);
		check(bankOpen, 8'h20);
		issue(2'h1, 3'h5, 1'b0, 1'b1, 32'h0);
		t0 = tk;
		issue(2'h0, 3'h5, 1'b0, 1'b0, 32'h0);
		e = 4 + ru(sdram_sched_pkg::SINGLE_BANK_CLOSE_TIME_PS);
		check(1'((tk - t0) / 50 >= e), 1'b1);
		issue(2'h0, 3'h3, 1'b0, 1'b0, 32'h0);
		issue(2'h2, 3'h3, 1'b0, 1'b0, $urandom);
		issue(2'h2, 3'h5, 1'b0, 1'b1, $urandom);
		at(10);
		check({arrayWrite, bankOpen}, 9'h128);
		at(1);
		check(bankOpen, 8'h08);
		at(5);
		check(expQ.size(), 0);
		close_out();
	end
endmodule
`default_nettype wire
